/* logic/smp_pkg.sv */
`default_nettype none
package smp_pkg;
   localparam int          NUM_SOCKETS       = 8;
   // Register map, byte addresses on the serial port.
   localparam logic [15:0] ADDR_INT_MASK     = 16'h0016;
   localparam logic [15:0] ADDR_INT_SUMMARY  = 16'h0034;
   localparam logic [15:0] ADDR_PHY_STATUS   = 16'h0035;
   localparam logic [15:0] ADDR_SOCK_BASE    = 16'h4000;
   localparam logic [15:0] ADDR_SOCK_STRIDE  = 16'h0100;
   localparam logic [4:0]  SOCK_WINDOW_TOP   = 5'h08;
   // Reset values.
   localparam logic [7:0]  RESET_INT_MASK    = 8'h00;
   localparam logic [7:0]  RESET_MODE        = 8'h00;
   // Status register fields.
   localparam int          PHY_LINK_BIT      = 5;
   localparam int          PHY_SLEEP_BIT     = 3;
   // Mode register fields.
   localparam int          MODE_MULTI_BIT    = 7;
   localparam int          MODE_FILTER_BIT   = 6;
   localparam int          MODE_ACK_IGMP_BIT = 5;
   localparam logic [7:0]  MODE_WRITE_MASK   = 8'hef;
   // Protocol codes held in mode bits 3 to 0.
   localparam logic [3:0]  PROTO_CLOSED      = 4'h0;
   localparam logic [3:0]  PROTO_TCP         = 4'h1;
   localparam logic [3:0]  PROTO_UDP         = 4'h2;
   localparam logic [3:0]  PROTO_RAW_IP      = 4'h3;
   localparam logic [3:0]  PROTO_RAW_MAC     = 4'h4;
   localparam logic [3:0]  PROTO_PPPOE       = 4'h5;
   // Serial frame: 16 address bits, 1 direction bit, 15 length bits.
   localparam logic [4:0]  HEADER_LAST_BIT   = 5'h1f;
   localparam logic [4:0]  BYTE_LAST_BIT     = 5'h07;
   typedef enum logic [1:0] {SMP_HEADER, SMP_DATA, SMP_DONE} smp_phase_t;
endpackage
`default_nettype wire

/* logic/smp_regs.sv */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// R1: Status bit 5 reads 1 while the link is up, 0 when down.
// R2: Status bit 3 reads 1 while the PHY is in power-down mode.
// R3: A set mask bit passes its socket summary bit onto the interrupt pin.
// R4: A cleared mask bit keeps that summary bit off the pin.
// R5: Mode bit 7 enables multicast, effective only in UDP mode.
// R6: Host loads group address and port before opening a multicast socket; the testbench opens socket 1 in multicast with only its mode written.
// R7: In raw MAC mode bit 6 filters to own and broadcast frames.
// R8: Host running its own stack should set the frame filter bit.
// R9: In TCP mode bit 5 set requests immediate acknowledgements.
// R10: In TCP mode bit 5 clear leaves acknowledgements delayed.
// R11: In multicast UDP bit 5 picks IGMP version: 0 is v2, 1 is v1.
// R12: Mode bits 3 to 0 select protocol; bit 4 is reserved.
// R13: Raw MAC and PPPoE codes are accepted only on socket 0.
// R14: Eight mode registers at 0x4000 plus n times 0x0100, reset zero.
// R15: Summary bit sets on a socket event, clears when its events clear.
module smp_regs (
   // Clock and reset
   input  wire logic                                 clock,
   input  wire logic                                 reset,
   // Serial register port
   input  wire logic                                 spi_sclk,
   input  wire logic                                 spi_cs_n,
   input  wire logic                                 spi_mosi,
   output logic                                      spi_miso,
   output logic                                      spi_miso_oe,
   // Physical layer state
   input  wire logic                                 phy_link_up,
   input  wire logic                                 phy_sleep_flag,
   // Socket events
   input  wire logic [smp_pkg::NUM_SOCKETS-1:0]      socket_event_set,
   input  wire logic [smp_pkg::NUM_SOCKETS-1:0]      socket_event_cleared,
   output logic                                      interrupt_out_low,
   // Decoded socket options
   output logic [smp_pkg::NUM_SOCKETS*4-1:0]         socket_protocol,
   output logic [smp_pkg::NUM_SOCKETS-1:0]           multicast_active,
   output logic [smp_pkg::NUM_SOCKETS-1:0]           frame_filter_enable,
   output logic [smp_pkg::NUM_SOCKETS-1:0]           quick_ack_enable,
   output logic [smp_pkg::NUM_SOCKETS-1:0]           igmp_v1_select
);
   import smp_pkg::*;

   logic [7:0]             socket_interrupt_mask;
   logic [7:0]             socket_interrupt_summary;
   logic [7:0]             phy_link_status;
   logic [7:0]             socket_mode [NUM_SOCKETS];
   logic                   sclk_q;
   logic                   sclk_rise;
   logic                   sclk_fall;
   smp_phase_t             phase;
   logic [4:0]             bit_cnt;
   logic [31:0]            shift_in;
   logic [7:0]             shift_out;
   logic [15:0]            cur_addr;
   logic                   is_write;
   logic [14:0]            remaining;
   logic                   wr_strobe;
   logic [15:0]            wr_addr;
   logic [7:0]             wr_data;
   logic [31:0]            next_header;
   logic [7:0]             next_byte;

   function automatic logic is_mode_addr(input logic [15:0] a);
      return (a[15:11] == SOCK_WINDOW_TOP) && (a[7:0] == 8'h00);
   endfunction

   function automatic logic [7:0] read_reg(input logic [15:0] a);
      logic [7:0] d;
      d = 8'h00;
      if (a == ADDR_INT_MASK) begin
         d = socket_interrupt_mask;
      end else if (a == ADDR_INT_SUMMARY) begin
         d = socket_interrupt_summary;
      end else if (a == ADDR_PHY_STATUS) begin
         d = phy_link_status;
      end else if (is_mode_addr(a)) begin
         d = socket_mode[a[10:8]];
      end
      return d;
   endfunction

   function automatic logic [3:0] proto_of(input logic [7:0] m);
      return m[3:0];
   endfunction

   assign sclk_rise   = spi_sclk & ~sclk_q;
   assign sclk_fall   = ~spi_sclk & sclk_q;
   assign next_header = {shift_in[30:0], spi_mosi};
   assign next_byte   = {shift_in[6:0], spi_mosi};

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= spi_sclk;
      end
   end

   // Pins are sampled on the system clock, so the serial clock must run
   // well below half the system rate for its edges to be seen.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         phase     <= SMP_HEADER;
         bit_cnt   <= 5'h00;
         shift_in  <= 32'h0000_0000;
         cur_addr  <= 16'h0000;
         is_write  <= 1'b0;
         remaining <= 15'h0000;
         wr_strobe <= 1'b0;
         wr_addr   <= 16'h0000;
         wr_data   <= 8'h00;
      end else begin
         wr_strobe <= 1'b0;
         if (spi_cs_n) begin
            phase   <= SMP_HEADER;
            bit_cnt <= 5'h00;
         end else if (sclk_rise) begin
            shift_in <= next_header;
            bit_cnt  <= bit_cnt + 5'h01;
            case (phase)
               SMP_HEADER: begin
                  if (bit_cnt == HEADER_LAST_BIT) begin
                     cur_addr  <= next_header[31:16];
                     is_write  <= next_header[15];
                     remaining <= next_header[14:0];
                     bit_cnt   <= 5'h00;
                     phase     <= (next_header[14:0] == 15'h0000) ?
                                  SMP_DONE : SMP_DATA;
                  end
               end
               SMP_DATA: begin
                  if (bit_cnt == BYTE_LAST_BIT) begin
                     wr_strobe <= is_write;
                     wr_addr   <= cur_addr;
                     wr_data   <= next_byte;
                     cur_addr  <= cur_addr + 16'h0001;
                     remaining <= remaining - 15'h0001;
                     bit_cnt   <= 5'h00;
                     if (remaining == 15'h0001) begin
                        phase <= SMP_DONE;
                     end
                  end
               end
               SMP_DONE: begin
                  bit_cnt <= 5'h00;
               end
               default: begin
                  phase <= SMP_HEADER;
               end
            endcase
         end
      end
   end

   // Read data is fetched at the last rising edge before each byte, so the
   // first bit is on the pin before the host samples it.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         shift_out   <= 8'h00;
         spi_miso    <= 1'b0;
         spi_miso_oe <= 1'b0;
      end else begin
         spi_miso_oe <= ~spi_cs_n;
         if (spi_cs_n) begin
            spi_miso <= 1'b0;
         end else if (sclk_rise && phase == SMP_HEADER &&
                      bit_cnt == HEADER_LAST_BIT) begin
            shift_out <= read_reg(next_header[31:16]);
         end else if (sclk_rise && phase == SMP_DATA &&
                      bit_cnt == BYTE_LAST_BIT) begin
            shift_out <= read_reg(cur_addr + 16'h0001);
         end else if (sclk_fall) begin
            spi_miso  <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         socket_interrupt_mask <= RESET_INT_MASK;
      end else if (wr_strobe && wr_addr == ADDR_INT_MASK) begin
         socket_interrupt_mask <= wr_data;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < NUM_SOCKETS; i++) begin
            socket_mode[i] <= RESET_MODE;
         end
      // R14: per-socket mode registers
      end else if (wr_strobe && is_mode_addr(wr_addr)) begin
         // R12: reserved bit dropped
         socket_mode[wr_addr[10:8]] <= wr_data & MODE_WRITE_MASK;
         // R13: socket 0 only
         if (wr_addr[10:8] != 3'h0 &&
             (wr_data[3:0] == PROTO_RAW_MAC ||
              wr_data[3:0] == PROTO_PPPOE)) begin
            socket_mode[wr_addr[10:8]] <=
               (wr_data & MODE_WRITE_MASK & 8'hf0) | {4'h0, PROTO_CLOSED};
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         phy_link_status <= 8'h00;
      end else begin
         phy_link_status <= 8'h00;
         // R1: link state
         phy_link_status[PHY_LINK_BIT]  <= phy_link_up;
         // R2: power-down state
         phy_link_status[PHY_SLEEP_BIT] <= phy_sleep_flag;
      end
   end

   // A new event wins over a clear in the same cycle so it is never lost.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         socket_interrupt_summary <= 8'h00;
      end else begin
         for (int i = 0; i < NUM_SOCKETS; i++) begin
            // R15: set and auto-clear
            if (socket_event_set[i]) begin
               socket_interrupt_summary[i] <= 1'b1;
            end else if (socket_event_cleared[i]) begin
               socket_interrupt_summary[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         interrupt_out_low <= 1'b1;
      end else begin
         // R3: R4: mask gating
         interrupt_out_low <=
            ~|(socket_interrupt_summary & socket_interrupt_mask);
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         socket_protocol     <= '0;
         multicast_active    <= '0;
         frame_filter_enable <= '0;
         quick_ack_enable    <= '0;
         igmp_v1_select      <= '0;
      end else begin
         for (int i = 0; i < NUM_SOCKETS; i++) begin
            socket_protocol[i*4 +: 4] <= proto_of(socket_mode[i]);
            // R5: multicast in UDP only
            multicast_active[i] <= socket_mode[i][MODE_MULTI_BIT] &&
                                   proto_of(socket_mode[i]) == PROTO_UDP;
            // R7: raw MAC frame filter
            frame_filter_enable[i] <= socket_mode[i][MODE_FILTER_BIT] &&
                              proto_of(socket_mode[i]) == PROTO_RAW_MAC;
            // R9: R10: acknowledgement timing
            quick_ack_enable[i] <= socket_mode[i][MODE_ACK_IGMP_BIT] &&
                                   proto_of(socket_mode[i]) == PROTO_TCP;
            // R11: IGMP version select
            igmp_v1_select[i] <= socket_mode[i][MODE_ACK_IGMP_BIT] &&
                                 socket_mode[i][MODE_MULTI_BIT] &&
                                 proto_of(socket_mode[i]) == PROTO_UDP;
         end
      end
   end
endmodule
`default_nettype wire

/* sim/smp_regs_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module smp_regs_properties (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // Observed ports
   input  wire logic [7:0]  socket_event_set,
   input  wire logic [7:0]  socket_event_cleared,
   input  wire logic        interrupt_out_low,
   input  wire logic [31:0] socket_protocol,
   input  wire logic [7:0]  multicast_active,
   input  wire logic [7:0]  frame_filter_enable,
   input  wire logic [7:0]  quick_ack_enable,
   input  wire logic [7:0]  igmp_v1_select
);
   logic [7:0] is_tcp, is_udp, is_mac, is_raw, is_high;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         is_tcp[i]  = socket_protocol[4*i+:4] == 4'h1;
         is_udp[i]  = socket_protocol[4*i+:4] == 4'h2;
         is_mac[i]  = socket_protocol[4*i+:4] == 4'h4;
         is_raw[i]  = is_mac[i] || socket_protocol[4*i+:4] == 4'h5;
         is_high[i] = socket_protocol[4*i+:4] > 4'h5;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // All events cleared and nothing new lets the pin go idle.
   sequence all_clear;
      (&socket_event_cleared) && !(|socket_event_set);
   endsequence
   sequence no_new;
      !(|socket_event_set);
   endsequence
   multi_udp_a: assert property (
      (multicast_active & ~is_udp) == 8'h00) else $error("multicast off UDP");
   filter_raw_a: assert property (
      (frame_filter_enable & ~is_mac) == 8'h00) else $error("filter off raw");
   quick_tcp_a: assert property (
      (quick_ack_enable & ~is_tcp) == 8'h00) else $error("quick ack off TCP");
   igmp_multi_a: assert property (
      (igmp_v1_select & ~multicast_active) == 8'h00) else $error("igmp bad");
   proto_range_a: assert property (
      is_high == 8'h00) else $error("protocol code out of range");
   raw_sock0_a: assert property (
      is_raw[7:1] == 7'h00) else $error("raw mode on socket above 0");
   mode_reset_a: assert property (
      $fell(reset) |-> socket_protocol == 32'h0 && quick_ack_enable == 8'h00)
      else $error("mode not zero after reset");
   irq_release_a: assert property (
      all_clear ##1 no_new |=> interrupt_out_low) else $error("irq stuck");
endmodule
bind smp_regs smp_regs_properties smp_regs_properties_i (.clock, .reset,
   .socket_event_set, .socket_event_cleared, .interrupt_out_low,
   .socket_protocol, .multicast_active, .frame_filter_enable,
   .quick_ack_enable, .igmp_v1_select);
`default_nettype wire

/* sim/smp_host.sv */
`timescale 1ns/10ps
`default_nettype none
module smp_host (
   // Clock
   input  wire logic clock,
   // Serial register port
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_mosi,
   input  wire logic spi_miso
);
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end
   // Idle data toggles so a stale level never passes for data.
   always @(negedge clock) begin
      if (spi_cs_n) spi_mosi <= ~spi_mosi;
   end
   // Slow edges give the device's edge detector ample margin.
   task automatic xfer(input logic [15:0] a, input logic w,
                       input logic [7:0] d, output logic [7:0] q);
      logic [39:0] f;
      f = {a, w, 15'h0001, d};
      q = 8'h00;
      spi_cs_n <= 1'b0;
      @(negedge clock);
      for (int i = 39; i >= 0; i--) begin
         spi_mosi <= f[i];
         repeat (4) @(negedge clock);
         if (i < 8) q[i] = spi_miso;
         spi_sclk <= 1'b1;
         repeat (2) @(negedge clock);
         spi_sclk <= 1'b0;
      end
      repeat (4) @(negedge clock);
      spi_cs_n <= 1'b1;
      @(negedge clock);
   endtask
endmodule
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import smp_pkg::*;
   logic        clock, reset, spi_sclk, spi_cs_n, spi_mosi, spi_miso;
   logic        spi_miso_oe;
   logic        phy_link_up, phy_sleep_flag, interrupt_out_low;
   logic [7:0]  socket_event_set, socket_event_cleared, rd, m, v, e;
   logic [7:0]  multicast_active, frame_filter_enable;
   logic [7:0]  quick_ack_enable, igmp_v1_select;
   logic [31:0] socket_protocol;
   logic [15:0] a;
   int          errors, n_tests, seed, n;
   smp_regs smp_regs_i (.clock, .reset, .spi_sclk, .spi_cs_n, .spi_mosi,
      .spi_miso, .spi_miso_oe, .phy_link_up, .phy_sleep_flag,
      .socket_event_set, .socket_event_cleared, .interrupt_out_low,
      .socket_protocol, .multicast_active, .frame_filter_enable,
      .quick_ack_enable, .igmp_v1_select);
   smp_host smp_host_i (.clock, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task check(input logic [31:0] s, input logic [31:0] x);
      n_tests++;
      if (s !== x) begin
         errors++;
         $display("[ERR] %0t saw %h expected %h", $time, s, x);
      end
   endtask
   task end_sim;
      if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic logic [7:0] exp_mode(int s, logic [7:0] x);
      exp_mode = x & MODE_WRITE_MASK;
      if (s != 0 && (x[3:0] == PROTO_RAW_MAC || x[3:0] == PROTO_PPPOE))
         exp_mode[3:0] = PROTO_CLOSED;
   endfunction
   initial begin
      repeat (100000) @(posedge clock);
      errors++;
      end_sim;
   end
   initial begin
      seed = 66001;
      errors = 0;
      n_tests = 0;
      reset = 1'b1;
      {phy_link_up, phy_sleep_flag} = 2'b00;
      socket_event_set = 8'h00;
      socket_event_cleared = 8'h00;
      repeat (10) @(negedge clock);
      reset = 1'b0;
      @(negedge clock);
      smp_host_i.xfer(ADDR_INT_MASK, 1'b0, 8'h00, rd);
      check(rd, RESET_INT_MASK);
      check(spi_miso_oe, 1'b0);
      smp_host_i.xfer(16'h4001, 1'b0, 8'h00, rd);
      check(rd, 8'h00);
      for (int k = 0; k < 4; k++) begin
         {phy_link_up, phy_sleep_flag} = k[1:0];
         smp_host_i.xfer(ADDR_PHY_STATUS, 1'b0, 8'h00, rd);
         check(rd, {2'b00, k[1], 1'b0, k[0], 3'b000});
      end
      for (int k = 0; k < 18; k++) begin
         n = (k < 16) ? k % 8 : 0;
         v = 8'($random(seed));
         v[3:0] = (k < 16) ? 4'(k % 6) : 4'(k - 12);
         a = ADDR_SOCK_BASE + 16'(n) * ADDR_SOCK_STRIDE;
         smp_host_i.xfer(a, 1'b1, v, rd);
         smp_host_i.xfer(a, 1'b0, 8'h00, rd);
         e = exp_mode(n, v);
         check(rd, e);
         check(socket_protocol[4*n+:4], e[3:0]);
         check(multicast_active[n], e[7] && e[3:0] == PROTO_UDP);
         check(frame_filter_enable[n], e[6] && e[3:0] == PROTO_RAW_MAC);
         check(quick_ack_enable[n], e[5] && e[3:0] == PROTO_TCP);
         check(igmp_v1_select[n], e[5] && e[7] && e[3:0] == PROTO_UDP);
      end
      smp_host_i.xfer(ADDR_SOCK_BASE, 1'b1, 8'h44, rd);
      check(frame_filter_enable[0], 1'b1);
      // no group address or port is loaded before this open; only the mode is written.
      smp_host_i.xfer(ADDR_SOCK_BASE + ADDR_SOCK_STRIDE, 1'b1, 8'h82, rd);
      check(multicast_active[1], 1'b1);
      for (int s = 0; s < 8; s++) begin
         m = (s == 0) ? 8'hff : (s == 1) ? 8'h00 : 8'($random(seed));
         smp_host_i.xfer(ADDR_INT_MASK, 1'b1, m, rd);
         socket_event_set = 8'h01 << s;
         @(negedge clock);
         socket_event_set = 8'h00;
         repeat (3) @(negedge clock);
         check(interrupt_out_low, !m[s]);
         if (!m[s]) begin
            smp_host_i.xfer(ADDR_INT_MASK, 1'b1, 8'h01 << s, rd);
            check(interrupt_out_low, 1'b0);
         end
         socket_event_cleared = 8'hff;
         @(negedge clock);
         socket_event_cleared = 8'h00;
         repeat (3) @(negedge clock);
         check(interrupt_out_low, 1'b1);
      end
      end_sim;
   end
endmodule
`default_nettype wire
